// ==== rtl/pmsc_map.svh ====
// register offsets, field positions, reset values and timing constants
`ifndef PMSC_MAP_SVH
`define PMSC_MAP_SVH

// register indices, byte address is four times the index
`define PMSC_IDX_PDC1 8'h0E
`define PMSC_IDX_SDC 8'h0F
`define PMSC_IDX_STAT 8'h7F

// field positions
`define PMSC_PLL_BIT 5
`define PMSC_MODE_MSB 4
`define PMSC_MODE_LSB 3
`define PMSC_STAT_SLEEP_BIT 0
`define PMSC_STAT_COUNT_BIT 1
`define PMSC_STAT_PLLPD_BIT 2

// reset values
`define PMSC_PLL_RST 1'h0
`define PMSC_MODE_RST 2'h0
`define PMSC_GST_RST 8'h50

// timing: go-sleep unit in ms, clock rate in kHz
`define PMSC_TICK_MS 20
`define PMSC_CLK_KHZ 40000

// bus responses
`define PMSC_RESP_OKAY 2'h0
`define PMSC_RESP_SLVERR 2'h2

`endif

// ==== rtl/pmsc_pkg.sv ====
// types shared by the power mode and sleep control block
package pmsc_pkg;

  typedef enum logic [1:0] {
    PMSC_MODE_NORMAL = 2'h0,
    PMSC_MODE_ENERGY = 2'h1,
    PMSC_MODE_SOFTPD = 2'h2,
    PMSC_MODE_SAVING = 2'h3
  } pmsc_mode_t;

  typedef enum logic [1:0] {
    PMSC_ST_ACTIVE = 2'h0,
    PMSC_ST_COUNT = 2'h1,
    PMSC_ST_SLEEP = 2'h3
  } pmsc_state_t;

endpackage : pmsc_pkg

// ==== rtl/pmsc_sleep_if.sv ====
// carrier between controller, tick generator and no-energy timer
`timescale 1ns/1ps
interface pmsc_sleep_if;
  logic clear;
  logic tick;
  logic [7:0] go_sleep_time;
  logic expired;

  modport ctrl_mp (output clear, output go_sleep_time, input expired);
  modport tick_mp (input clear, output tick);
  modport timer_mp (input clear, input tick, input go_sleep_time,
                    output expired);
endinterface : pmsc_sleep_if

// ==== rtl/pmsc_sleep_timer.sv ====
// counts whole no-energy units against the go-sleep time
`timescale 1ns/1ps
module pmsc_sleep_timer (
  input wire logic aclk,
  input wire logic aresetn,
  pmsc_sleep_if.timer_mp sif
);
  import pmsc_pkg::*;

  logic [7:0] units_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn || sif.clear) begin
      units_ff <= 8'h00;
    end else if (sif.tick && units_ff != 8'hFF) begin
      units_ff <= units_ff + 8'h01;
    end
  end

  assign sif.expired = (units_ff >= sif.go_sleep_time);
endmodule : pmsc_sleep_timer

// ==== rtl/pmsc_tick.sv ====
// unit tick generator, one pulse per go-sleep time unit
`timescale 1ns/1ps
module pmsc_tick #(
  parameter int TICK_CYCLES = 800000
) (
  input wire logic aclk,
  input wire logic aresetn,
  pmsc_sleep_if.tick_mp sif
);
  import pmsc_pkg::*;

  localparam int CW = $clog2(TICK_CYCLES + 1);

  logic [CW-1:0] cyc_ff;
  logic at_end;

  assign at_end = (cyc_ff == CW'(TICK_CYCLES - 1));

  // restarts with the measurement so every unit is whole
  always_ff @(posedge aclk) begin
    if (!aresetn || sif.clear || at_end) begin
      cyc_ff <= '0;
    end else begin
      cyc_ff <= cyc_ff + CW'(1);
    end
  end

  assign sif.tick = at_end && !sif.clear;
endmodule : pmsc_tick

// ==== rtl/pmsc_top.sv ====
// power management mode and go-sleep control with AXI4-Lite registers
// ==========================================================
`timescale 1ns/1ps
`include "pmsc_map.svh"
module pmsc_top #(
  parameter int ADDR_W = 12,
  parameter int TICK_CYCLES = `PMSC_TICK_MS * `PMSC_CLK_KHZ
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic energy_seen,
  output pmsc_pkg::pmsc_mode_t pm_mode,
  output logic low_power,
  output logic pll_power_down,
  output logic soft_power_down,
  output logic power_saving
);
  import pmsc_pkg::*;

  // ==========================================================
  // address decode
  // ==========================================================
  // word index of an aligned address below 1024, 8'h00 and bad flag otherwise
  function automatic logic [8:0] reg_index(input logic [ADDR_W-1:0] a);
    logic [8:0] r;
    r = 9'h100;
    if (a[1:0] == 2'h0 && (a >> 10) == '0) begin
      r = {1'b0, a[9:2]};
    end
    return r;
  endfunction : reg_index

  // true when a decoded index selects the given register
  function automatic logic idx_is(input logic [8:0] idx,
                                  input logic [7:0] sel);
    return idx == {1'b0, sel};
  endfunction : idx_is

  function automatic logic is_mapped(input logic [8:0] idx);
    return idx_is(idx, `PMSC_IDX_PDC1) || idx_is(idx, `PMSC_IDX_SDC)
        || idx_is(idx, `PMSC_IDX_STAT);
  endfunction : is_mapped

  // ==========================================================
  // registers
  // ==========================================================
  logic pll_pd_off_ff;
  pmsc_mode_t mode_ff;
  logic [7:0] go_sleep_ff;
  pmsc_state_t state_ff;
  pmsc_state_t nxt_state;

  // ==========================================================
  // write channel
  // ==========================================================
  logic aw_held_ff;
  logic w_held_ff;
  logic [ADDR_W-1:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic do_write;
  logic [8:0] widx;

  assign s_axi_awready = !aw_held_ff && !bvalid_ff;
  assign s_axi_wready = !w_held_ff && !bvalid_ff;
  // commit once address and data are held and no response waits
  assign do_write = aw_held_ff && w_held_ff && !bvalid_ff;
  assign widx = reg_index(awaddr_ff);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_ff <= 1'b0;
      awaddr_ff <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_ff <= 1'b1;
      awaddr_ff <= s_axi_awaddr;
    end else if (do_write) begin
      aw_held_ff <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_ff <= 1'b0;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_ff <= 1'b1;
      wdata_ff <= s_axi_wdata;
      wstrb_ff <= s_axi_wstrb;
    end else if (do_write) begin
      w_held_ff <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_ff <= 1'b0;
      bresp_ff <= `PMSC_RESP_OKAY;
    end else if (do_write) begin
      bvalid_ff <= 1'b1;
      bresp_ff <= is_mapped(widx) ? `PMSC_RESP_OKAY : `PMSC_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;

  // control 1: pll power down disable and mode, other bits read zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pll_pd_off_ff <= `PMSC_PLL_RST;
      mode_ff <= pmsc_mode_t'(`PMSC_MODE_RST);
    end else if (do_write && idx_is(widx, `PMSC_IDX_PDC1)
                 && wstrb_ff[0]) begin
      pll_pd_off_ff <= wdata_ff[`PMSC_PLL_BIT];
      mode_ff <= pmsc_mode_t'(
        wdata_ff[`PMSC_MODE_MSB:`PMSC_MODE_LSB]);
    end
  end

  // control 2: go-sleep time in 20 ms units
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      go_sleep_ff <= `PMSC_GST_RST;
    end else if (do_write && idx_is(widx, `PMSC_IDX_SDC)
                 && wstrb_ff[0]) begin
      go_sleep_ff <= wdata_ff[7:0];
    end
  end

  // ==========================================================
  // read channel
  // ==========================================================
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;
  logic [8:0] ridx;
  logic [31:0] rd_word;

  assign s_axi_arready = !rvalid_ff;
  assign ridx = reg_index(s_axi_araddr);

  // read word: control 1, control 2 or status (sleeping, counting, pll powered down)
  always_comb begin
    rd_word = 32'h0000_0000;
    if (idx_is(ridx, `PMSC_IDX_PDC1)) begin
      rd_word[`PMSC_PLL_BIT] = pll_pd_off_ff;
      rd_word[`PMSC_MODE_MSB:`PMSC_MODE_LSB] = mode_ff;
    end else if (idx_is(ridx, `PMSC_IDX_SDC)) begin
      rd_word[7:0] = go_sleep_ff;
    end else if (idx_is(ridx, `PMSC_IDX_STAT)) begin
      rd_word[`PMSC_STAT_SLEEP_BIT] = low_power;
      rd_word[`PMSC_STAT_COUNT_BIT] = (state_ff == PMSC_ST_COUNT);
      rd_word[`PMSC_STAT_PLLPD_BIT] = pll_power_down;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= `PMSC_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_ff <= 1'b1;
      rdata_ff <= rd_word;
      rresp_ff <= is_mapped(ridx) ? `PMSC_RESP_OKAY : `PMSC_RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;

  // ==========================================================
  // no-energy measurement
  // ==========================================================
  // tick and unit count restart together with every measurement
  pmsc_sleep_if sif ();

  pmsc_tick #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_tick (
    .aclk(aclk),
    .aresetn(aresetn),
    .sif(sif.tick_mp)
  );

  pmsc_sleep_timer u_timer (
    .aclk(aclk),
    .aresetn(aresetn),
    .sif(sif.timer_mp)
  );

  logic energy_mode;

  assign energy_mode = (mode_ff == PMSC_MODE_ENERGY);
  assign sif.clear = (state_ff != PMSC_ST_COUNT);
  assign sif.go_sleep_time = go_sleep_ff;

  // ==========================================================
  // sleep state machine
  // ==========================================================
  // energy or leaving energy detection ends low power at once
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      PMSC_ST_ACTIVE: begin
        if (energy_mode && !energy_seen) begin
          nxt_state = PMSC_ST_COUNT;
        end
      end
      PMSC_ST_COUNT: begin
        if (!energy_mode || energy_seen) begin
          nxt_state = PMSC_ST_ACTIVE;
        end else if (sif.expired) begin
          nxt_state = PMSC_ST_SLEEP;
        end
      end
      PMSC_ST_SLEEP: begin
        if (!energy_mode || energy_seen) begin
          nxt_state = PMSC_ST_ACTIVE;
        end
      end
      default: begin
        nxt_state = PMSC_ST_ACTIVE;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_ff <= PMSC_ST_ACTIVE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ==========================================================
  // power outputs
  // ==========================================================
  logic low_power_ff;
  logic pll_pd_ff;
  logic soft_pd_ff;
  logic saving_ff;
  pmsc_mode_t pm_mode_ff;

  // low power and pll outputs follow the next state so they move with it, mode outputs follow mode_ff
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      low_power_ff <= 1'b0;
      pll_pd_ff <= 1'b0;
      soft_pd_ff <= 1'b0;
      saving_ff <= 1'b0;
      pm_mode_ff <= PMSC_MODE_NORMAL;
    end else begin
      low_power_ff <= (nxt_state == PMSC_ST_SLEEP);
      pll_pd_ff <= (nxt_state == PMSC_ST_SLEEP) && energy_mode
                   && !pll_pd_off_ff;
      soft_pd_ff <= (mode_ff == PMSC_MODE_SOFTPD);
      saving_ff <= (mode_ff == PMSC_MODE_SAVING);
      pm_mode_ff <= mode_ff;
    end
  end

  assign low_power = low_power_ff;
  assign pll_power_down = pll_pd_ff;
  assign soft_power_down = soft_pd_ff;
  assign power_saving = saving_ff;
  assign pm_mode = pm_mode_ff;
endmodule : pmsc_top

// ==== verification/pmsc_properties.sv ====
// checker for power mode and go-sleep control
`timescale 1ns/1ps
module pmsc_properties (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic energy_seen,
  input wire pmsc_pkg::pmsc_mode_t pm_mode,
  input wire logic low_power,
  input wire logic pll_power_down,
  input wire logic soft_power_down,
  input wire logic power_saving
);
  import pmsc_pkg::*;
  // =====
  // assertions
  logic [3:0] quiet_ff;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  always_ff @(posedge aclk) begin
    if (!aresetn || energy_seen) begin
      quiet_ff <= 4'h0;
    end else if (quiet_ff != 4'hF) begin
      quiet_ff <= quiet_ff + 4'h1;
    end
  end
  chk_pll_gate: assert property (
    pll_power_down |-> pm_mode == PMSC_MODE_ENERGY
      || $past(pm_mode) == PMSC_MODE_ENERGY) else $error("pll gate");
  chk_soft_mode: assert property (
    (pm_mode == PMSC_MODE_SOFTPD) [*2] |-> soft_power_down
      && !power_saving) else $error("soft mode");
  chk_saving_mode: assert property (
    (pm_mode == PMSC_MODE_SAVING) [*2] |-> power_saving
      && !soft_power_down) else $error("saving mode");
  chk_sleep_mode: assert property (
    (pm_mode != PMSC_MODE_ENERGY) [*2] |-> !low_power) else $error("mode");
  chk_quiet_wait: assert property (
    $rose(low_power) |-> quiet_ff != 4'h0) else $error("early sleep");
  chk_energy_wake: assert property (
    energy_seen |=> !low_power) else $error("no wake");
  chk_bresp_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
      && $stable(s_axi_bresp)) else $error("b hold");
  chk_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("r late");
  cover property ($rose(low_power));
  cover property (pll_power_down);
  cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule : pmsc_properties

bind pmsc_top pmsc_properties u_chk (.aclk, .aresetn, .s_axi_bvalid,
  .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .energy_seen, .pm_mode, .low_power, .pll_power_down,
  .soft_power_down, .power_saving);

// ==== verification/tb_top.sv ====
// self-checking bench for power mode and go-sleep control
`timescale 1ns/1ps
module tb_top;
  import pmsc_pkg::*;
  // =====
  // signals and design
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [11:0] s_axi_awaddr = '0;
  logic [11:0] s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0;
  logic s_axi_awvalid = 1'h0;
  logic s_axi_wvalid = 1'h0;
  logic s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0;
  logic s_axi_rready = 1'h0;
  logic energy_seen = 1'h1;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, low_power, pll_power_down, soft_power_down;
  logic power_saving;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  pmsc_mode_t pm_mode;
  int num_errors = 0;
  int total_checks = 0;
  always #12.5 aclk = ~aclk;
  pmsc_top #(.TICK_CYCLES(8)) dut (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0),
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .energy_seen, .pm_mode, .low_power,
    .pll_power_down, .soft_power_down, .power_saving);
  // =====
  // tasks
  task results;
    $display("errors %0d checks %0d", num_errors, total_checks);
    if (num_errors == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : results
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    logic ta, tw, ok;
    logic [1:0] rs;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    n = 0;
    do begin
      @(negedge aclk);
      ta = s_axi_awready;
      tw = s_axi_wready;
      ok = s_axi_bvalid;
      rs = s_axi_bresp;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'h0;
      if (tw) s_axi_wvalid <= 1'h0;
      n++;
    end while (!ok && n < 40);
    s_axi_bready <= 1'h0;
    chk(ok, 1'h1);
    if (!ok) results();
    chk(rs, r);
  endtask : wr
  task rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] r);
    int n;
    logic ta, ok;
    logic [1:0] rs;
    logic [31:0] d;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    n = 0;
    do begin
      @(negedge aclk);
      ta = s_axi_arready;
      ok = s_axi_rvalid;
      rs = s_axi_rresp;
      d = s_axi_rdata;
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 1'h0;
      n++;
    end while (!ok && n < 40);
    s_axi_rready <= 1'h0;
    chk(ok, 1'h1);
    if (!ok) results();
    chk(d, e);
    chk(rs, r);
  endtask : rd
  task sleep_in(input int lo, input int hi);
    int n;
    n = 0;
    while (low_power !== 1'h1 && n <= hi) begin
      @(posedge aclk);
      #1;
      n++;
    end
    chk(n >= lo && n <= hi, 1'h1);
    if (n > hi) results();
  endtask : sleep_in
  // =====
  // scenarios
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'h1;
    rd(12'h038, 32'h0, 2'h0);
    rd(12'h03C, 32'h50, 2'h0);
    for (int m = 0; m < 4; m++) begin
      wr(12'h038, 32'hC7 | (m << 3), 2'h0);
      rd(12'h038, m << 3, 2'h0);
      chk(pm_mode, m);
      chk(soft_power_down, m == 2);
      chk(power_saving, m == 3);
    end
    wr(12'h040, 32'h1, 2'h2);
    rd(12'h040, 32'h0, 2'h2);
    @(posedge aclk);
    energy_seen <= 1'h0;
    wr(12'h038, 32'h08, 2'h0);
    sleep_in(640, 644);
    repeat (2) @(posedge aclk);
    #1;
    chk(pll_power_down, 1'h1);
    rd(12'h1FC, 32'h5, 2'h0);
    @(posedge aclk);
    energy_seen <= 1'h1;
    wr(12'h03C, 32'h03, 2'h0);
    chk(low_power, 1'h0);
    @(posedge aclk);
    energy_seen <= 1'h0;
    repeat (12) @(posedge aclk);
    energy_seen <= 1'h1;
    @(posedge aclk);
    energy_seen <= 1'h0;
    sleep_in(24, 28);
    @(posedge aclk);
    energy_seen <= 1'h1;
    wr(12'h038, 32'h28, 2'h0);
    @(posedge aclk);
    energy_seen <= 1'h0;
    sleep_in(24, 28);
    repeat (2) @(posedge aclk);
    #1;
    chk(pll_power_down, 1'h0);
    wr(12'h038, 32'h18, 2'h0);
    repeat (2) @(posedge aclk);
    #1;
    chk({low_power, pll_power_down}, 2'h0);
    @(posedge aclk);
    aresetn <= 1'h0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    rd(12'h038, 32'h0, 2'h0);
    rd(12'h03C, 32'h50, 2'h0);
    chk(pm_mode, 2'h0);
    results();
  end
endmodule : tb_top
